//--- logic/eam_decode.sv
// special effective-address mode decoder with apb status registers
`timescale 1ns/1ps
`default_nettype none
module eam_decode
    import eam_pkg::*;
#(
    parameter int MAX_EXT = 6
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // operation word from the sequencer
    input  wire logic        op_valid,
    input  wire logic [15:0] op_word,
    input  wire logic [1:0]  op_size,
    input  wire logic        op_write,
    input  wire logic        op_first,
    input  wire logic [31:0] op_pc,
    output logic             op_ready,
    // extension words
    input  wire logic        ext_valid,
    input  wire logic [15:0] ext_word,
    output logic             ext_ready,
    // register file read port
    output logic      [3:0]  rf_sel,
    input  wire logic [31:0] rf_data,
    // results
    output logic             done,
    output logic             illegal,
    output logic             ea_valid,
    output logic             prog_space,
    output logic      [31:0] ea_addr,
    output logic             imm_valid,
    output logic      [31:0] imm_data,
    output logic      [2:0]  ext_used
);
    eam_state_t  state_ff, nxt_state;
    logic [15:0] words_ff [0:2];
    logic [15:0] nxt_words [0:2];
    logic [1:0]  wcnt_ff, nxt_wcnt, need_ff, nxt_need;
    logic [2:0]  sub_ff, nxt_sub, ext_tot_ff, nxt_ext_tot;
    logic [1:0]  size_ff, nxt_size;
    logic        wr_ff, nxt_wr, err_ff, nxt_err;
    logic [31:0] pc_ff, nxt_pc;
    logic [3:0]  rf_sel_ff, nxt_rf_sel;
    logic        op_ready_ff, nxt_op_ready, ext_ready_ff, nxt_ext_ready;
    logic        done_ff, nxt_done, illegal_ff, nxt_illegal;
    logic        ea_valid_ff, nxt_ea_valid, prog_ff, nxt_prog;
    logic        imm_valid_ff, nxt_imm_valid;
    logic [31:0] ea_addr_ff, nxt_ea_addr, imm_ff, nxt_imm;
    logic [2:0]  ext_used_ff, nxt_ext_used;
    logic [15:0] cnt_ff, nxt_cnt;
    logic        enable_ff, nxt_enable;
    logic        pready_ff, nxt_pready, slverr_ff, nxt_slverr;
    logic [31:0] prdata_ff, nxt_prdata;
    logic        is_pc, full_fmt;
    logic [1:0]  bd_sz;
    logic [31:0] base_v, disp_v;

    eam_idx_if ix ();
    assign ix.ext = words_ff[0];
    assign ix.rf  = rf_data;
    eam_index_calc u_idx (.ix(ix));

    assign is_pc    = (sub_ff == SUB_PC_DISP) || (sub_ff == SUB_PC_INDEX);
    assign full_fmt = words_ff[0][EXT_FULL];
    assign bd_sz    = words_ff[0][EXT_BD_HI:EXT_BD_LO];

    always_comb begin
        // zero pc; leaves only the index and the displacement
        base_v = (full_fmt && words_ff[0][EXT_BS]) ? 32'h0 : pc_ff;
        if (!full_fmt) begin
            disp_v = sext8(words_ff[0][7:0]);
        end else if (bd_sz == BD_WORD) begin
            disp_v = sext16(words_ff[1]);
        end else if (bd_sz == BD_LONG) begin
            disp_v = {words_ff[1], words_ff[2]};
        end else begin
            disp_v = 32'h0;
        end
    end

    always_comb begin
        logic [1:0] need_v;
        logic       err_v;
        need_v        = need_ff;
        err_v         = 1'b0;
        nxt_state     = state_ff;
        nxt_words     = words_ff;
        nxt_wcnt      = wcnt_ff;
        nxt_need      = need_ff;
        nxt_sub       = sub_ff;
        nxt_size      = size_ff;
        nxt_wr        = wr_ff;
        nxt_pc        = pc_ff;
        nxt_err       = err_ff;
        nxt_rf_sel    = rf_sel_ff;
        nxt_ext_tot   = ext_tot_ff;
        nxt_op_ready  = 1'b0;
        nxt_ext_ready = 1'b0;
        nxt_done      = 1'b0;
        nxt_ea_valid  = 1'b0;
        nxt_imm_valid = 1'b0;
        nxt_illegal   = illegal_ff;
        nxt_prog      = prog_ff;
        nxt_ea_addr   = ea_addr_ff;
        nxt_imm       = imm_ff;
        nxt_ext_used  = ext_used_ff;
        nxt_cnt       = cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                nxt_op_ready = enable_ff;
                if (op_valid && op_ready_ff) begin
                    nxt_op_ready = 1'b0;
                    nxt_sub  = op_word[EA_REG_HI:EA_REG_LO];
                    nxt_size = op_size;
                    nxt_wr   = op_write;
                    nxt_pc   = op_pc;
                    nxt_wcnt = 2'd0;
                    if (op_first) begin
                        nxt_ext_tot = 3'd0;
                    end
                    if (op_word[EA_REG_HI:EA_REG_LO] == SUB_ABS_LONG ||
                        (op_word[EA_REG_HI:EA_REG_LO] == SUB_IMM &&
                         op_size == SZ_LONG)) begin
                        nxt_need = 2'd2;
                    end else begin
                        nxt_need = 2'd1;
                    end
                    // submode only under the special mode
                    if (op_word[EA_MODE_HI:EA_MODE_LO] != MODE_SPECIAL ||
                        op_word[EA_REG_HI:EA_REG_LO] > SUB_IMM) begin
                        err_v = 1'b1;
                    end
                    if (op_word[EA_REG_HI:EA_REG_LO] == SUB_IMM &&
                        (op_size > SZ_LONG || op_write)) begin
                        err_v = 1'b1;
                    end
                    if (op_write &&
                        (op_word[EA_REG_HI:EA_REG_LO] == SUB_PC_DISP ||
                         op_word[EA_REG_HI:EA_REG_LO] == SUB_PC_INDEX)) begin
                        err_v = 1'b1;
                    end
                    nxt_err = err_v;
                    if (err_v) begin
                        nxt_state = ST_CALC;
                    end else begin
                        nxt_state     = ST_EXT;
                        nxt_ext_ready = 1'b1;
                    end
                end
            end
            ST_EXT: begin
                nxt_ext_ready = 1'b1;
                if (ext_valid && ext_ready_ff) begin
                    nxt_words[wcnt_ff] = ext_word;
                    nxt_wcnt = wcnt_ff + 2'd1;
                    if (wcnt_ff == 2'd0 && sub_ff == SUB_PC_INDEX) begin
                        nxt_rf_sel = ext_word[EXT_REG_HI:EXT_REG_LO];
                        if (ext_word[EXT_FULL]) begin
                            case (ext_word[EXT_BD_HI:EXT_BD_LO])
                                BD_NULL: need_v = 2'd1;
                                BD_WORD: need_v = 2'd2;
                                BD_LONG: need_v = 2'd3;
                                default: err_v = 1'b1;
                            endcase
                            if (ext_word[EXT_IIS_HI:EXT_IIS_LO] != 3'h0) begin
                                err_v = 1'b1;
                            end
                        end
                    end
                    if (ext_tot_ff >= 3'(MAX_EXT)) begin
                        err_v = 1'b1;
                    end else begin
                        nxt_ext_tot = ext_tot_ff + 3'd1;
                    end
                    nxt_need = need_v;
                    nxt_err  = err_v;
                    if (err_v || (wcnt_ff + 2'd1) == need_v) begin
                        nxt_state     = ST_CALC;
                        nxt_ext_ready = 1'b0;
                    end
                end
            end
            ST_CALC: begin
                nxt_state    = ST_IDLE;
                nxt_op_ready = enable_ff;
                nxt_done     = 1'b1;
                nxt_illegal  = err_ff;
                nxt_ext_used = {1'b0, wcnt_ff};
                nxt_cnt      = cnt_ff + 16'h0001;
                nxt_prog     = is_pc && !err_ff;
                if (!err_ff) begin
                    case (sub_ff)
                        SUB_ABS_SHORT: begin
                            nxt_ea_valid = 1'b1;
                            nxt_ea_addr  = sext16(words_ff[0]);
                        end
                        SUB_ABS_LONG: begin
                            nxt_ea_valid = 1'b1;
                            nxt_ea_addr  = {words_ff[0], words_ff[1]};
                        end
                        SUB_PC_DISP: begin
                            nxt_ea_valid = 1'b1;
                            nxt_ea_addr  = pc_ff + sext16(words_ff[0]);
                        end
                        SUB_PC_INDEX: begin
                            nxt_ea_valid = 1'b1;
                            nxt_ea_addr  = base_v + ix.index_val + disp_v;
                        end
                        SUB_IMM: begin
                            nxt_imm_valid = 1'b1;
                            case (size_ff)
                                SZ_BYTE: nxt_imm = {24'h0, words_ff[0][7:0]};
                                SZ_WORD: nxt_imm = {16'h0, words_ff[0]};
                                default: nxt_imm = {words_ff[0], words_ff[1]};
                            endcase
                        end
                        default: nxt_ea_valid = 1'b0;
                    endcase
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff     <= ST_IDLE;
            words_ff     <= '{16'h0, 16'h0, 16'h0};
            wcnt_ff      <= 2'd0;
            need_ff      <= 2'd1;
            sub_ff       <= 3'h0;
            size_ff      <= 2'h0;
            wr_ff        <= 1'b0;
            err_ff       <= 1'b0;
            pc_ff        <= 32'h0;
            rf_sel_ff    <= 4'h0;
            ext_tot_ff   <= 3'h0;
            op_ready_ff  <= 1'b0;
            ext_ready_ff <= 1'b0;
            done_ff      <= 1'b0;
            illegal_ff   <= 1'b0;
            ea_valid_ff  <= 1'b0;
            prog_ff      <= 1'b0;
            imm_valid_ff <= 1'b0;
            ea_addr_ff   <= 32'h0;
            imm_ff       <= 32'h0;
            ext_used_ff  <= 3'h0;
            cnt_ff       <= 16'h0;
        end else begin
            state_ff     <= nxt_state;
            words_ff     <= nxt_words;
            wcnt_ff      <= nxt_wcnt;
            need_ff      <= nxt_need;
            sub_ff       <= nxt_sub;
            size_ff      <= nxt_size;
            wr_ff        <= nxt_wr;
            err_ff       <= nxt_err;
            pc_ff        <= nxt_pc;
            rf_sel_ff    <= nxt_rf_sel;
            ext_tot_ff   <= nxt_ext_tot;
            op_ready_ff  <= nxt_op_ready;
            ext_ready_ff <= nxt_ext_ready;
            done_ff      <= nxt_done;
            illegal_ff   <= nxt_illegal;
            ea_valid_ff  <= nxt_ea_valid;
            prog_ff      <= nxt_prog;
            imm_valid_ff <= nxt_imm_valid;
            ea_addr_ff   <= nxt_ea_addr;
            imm_ff       <= nxt_imm;
            ext_used_ff  <= nxt_ext_used;
            cnt_ff       <= nxt_cnt;
        end
    end

    // read data is registered in the setup cycle, so every access
    // completes with exactly one access-phase cycle
    always_comb begin
        nxt_pready = 1'b0;
        nxt_slverr = 1'b0;
        nxt_prdata = prdata_ff;
        nxt_enable = enable_ff;
        if (psel && !penable) begin
            nxt_pready = 1'b1;
            case (paddr)
                ADDR_CTRL: nxt_prdata = {31'h0, enable_ff};
                ADDR_STAT: nxt_prdata = {27'h0, ext_tot_ff, illegal_ff,
                                         state_ff != ST_IDLE};
                ADDR_LAST: nxt_prdata = ea_addr_ff;
                ADDR_CNT:  nxt_prdata = {16'h0, cnt_ff};
                default: begin
                    nxt_prdata = 32'h0;
                    nxt_slverr = 1'b1;
                end
            endcase
        end
        if (psel && penable && pready_ff && pwrite && paddr == ADDR_CTRL) begin
            nxt_enable = pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            slverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
            enable_ff <= CTRL_ENABLE_RST;
        end else begin
            pready_ff <= nxt_pready;
            slverr_ff <= nxt_slverr;
            prdata_ff <= nxt_prdata;
            enable_ff <= nxt_enable;
        end
    end

    assign prdata     = prdata_ff;
    assign pready     = pready_ff;
    assign pslverr    = slverr_ff;
    assign op_ready   = op_ready_ff;
    assign ext_ready  = ext_ready_ff;
    assign rf_sel     = rf_sel_ff;
    assign done       = done_ff;
    assign illegal    = illegal_ff;
    assign ea_valid   = ea_valid_ff;
    assign prog_space = prog_ff;
    assign ea_addr    = ea_addr_ff;
    assign imm_valid  = imm_valid_ff;
    assign imm_data   = imm_ff;
    assign ext_used   = ext_used_ff;

    abs_short_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        done_ff && !illegal_ff && sub_ff == SUB_ABS_SHORT
        |-> ea_addr_ff == {{16{words_ff[0][15]}}, words_ff[0]})
        else $error("absolute short address wrong");
    abs_long_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        done_ff && !illegal_ff && sub_ff == SUB_ABS_LONG
        |-> ea_addr_ff == {words_ff[0], words_ff[1]} && ext_used_ff == 3'd2)
        else $error("absolute long address wrong");
    imm_byte_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        imm_valid_ff && size_ff == SZ_BYTE
        |-> imm_data == {24'h0, words_ff[0][7:0]} && !ea_valid_ff)
        else $error("byte immediate wrong");
    imm_long_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        imm_valid_ff && size_ff == SZ_LONG
        |-> imm_data == {words_ff[0], words_ff[1]})
        else $error("long immediate wrong");
    imm_words_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(done_ff) && !illegal_ff && sub_ff == SUB_IMM
        |-> ext_used_ff == (size_ff == SZ_LONG ? 3'd2 : 3'd1) ##1 !done_ff)
        else $error("immediate word count wrong");
    pc_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        done_ff && is_pc && wr_ff |-> illegal_ff && !ea_valid_ff && !prog_ff)
        else $error("pc mode write not refused");
    pc_brief_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        done_ff && !illegal_ff && sub_ff == SUB_PC_INDEX && !full_fmt
        |-> prog_ff && ea_addr_ff == pc_ff + sext8(words_ff[0][7:0])
            + $past(ix.index_val))
        else $error("pc index brief sum wrong");
    all_suppress_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        done_ff && !illegal_ff && sub_ff == SUB_PC_INDEX && full_fmt
        && words_ff[0][EXT_BS] && words_ff[0][EXT_IS] && bd_sz == BD_NULL
        |-> ea_addr_ff == 32'h0)
        else $error("suppressed terms not zero");
    indirect_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        done_ff && sub_ff == SUB_PC_INDEX && full_fmt
        && words_ff[0][EXT_IIS_HI:EXT_IIS_LO] != 3'h0 |-> illegal_ff)
        else $error("indirect select not illegal");
    ext_limit_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ext_tot_ff <= 3'(MAX_EXT))
        else $error("extension word count past limit");
endmodule
`default_nettype wire

//--- inc/eam_pkg.sv
// constants, types and helpers for the special ea mode decoder
// Behaviour
// - pc index address is pc+index+displacement
// - base displacement is 16 or 32 bits, sign-extended
// - pc used is first extension word address
// - pc modes are program space, reads only
// - pc, index, displacement each omittable; zero pc
// - zero pc with data index reads program space
// - absolute short address sign-extended to 32
// - absolute long: first word high, second low
// - byte immediate from low byte of word
// - word immediate is the whole word
// - long immediate: first high, second low
// - mode 111 register 100 is immediate
// - mode selects; register selects submode under 111
// - brief format single extension word supported
// - full format with base displacement words
// - up to six extension words per instruction
// - ea field is mode and register subfields
// - index type bit 15, number bits 14-12
// - bit 11 picks word or long index
// - bits 10-9 scale index by 1,2,4,8
package eam_pkg;
    localparam logic [2:0] MODE_SPECIAL  = 3'h7;
    localparam logic [2:0] SUB_ABS_SHORT = 3'h0;
    localparam logic [2:0] SUB_ABS_LONG  = 3'h1;
    localparam logic [2:0] SUB_PC_DISP   = 3'h2;
    localparam logic [2:0] SUB_PC_INDEX  = 3'h3;
    localparam logic [2:0] SUB_IMM       = 3'h4;
    localparam int EA_MODE_HI   = 5;
    localparam int EA_MODE_LO   = 3;
    localparam int EA_REG_HI    = 2;
    localparam int EA_REG_LO    = 0;
    localparam int EXT_REG_HI   = 15;
    localparam int EXT_REG_LO   = 12;
    localparam int EXT_WL       = 11;
    localparam int EXT_SCALE_HI = 10;
    localparam int EXT_SCALE_LO = 9;
    localparam int EXT_FULL     = 8;
    localparam int EXT_BS       = 7;
    localparam int EXT_IS       = 6;
    localparam int EXT_BD_HI    = 5;
    localparam int EXT_BD_LO    = 4;
    localparam int EXT_IIS_HI   = 2;
    localparam int EXT_IIS_LO   = 0;
    localparam logic [1:0] BD_RSVD = 2'h0;
    localparam logic [1:0] BD_NULL = 2'h1;
    localparam logic [1:0] BD_WORD = 2'h2;
    localparam logic [1:0] BD_LONG = 2'h3;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_LAST = 8'h08;
    localparam logic [7:0] ADDR_CNT  = 8'h0c;
    localparam logic CTRL_ENABLE_RST = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXT  = 3'b010,
        ST_CALC = 3'b100
    } eam_state_t;

    function automatic logic [31:0] sext16(input logic [15:0] v);
        sext16 = {{16{v[15]}}, v};
    endfunction

    function automatic logic [31:0] sext8(input logic [7:0] v);
        sext8 = {{24{v[7]}}, v};
    endfunction
endpackage

//--- inc/eam_idx_if.sv
// carrier between the decoder and its index scaler
`timescale 1ns/1ps
`default_nettype none
interface eam_idx_if;
    logic [15:0] ext;
    logic [31:0] rf;
    logic [31:0] index_val;
    modport calc (input ext, input rf, output index_val);
    modport user (output ext, output rf, input index_val);
endinterface
`default_nettype wire

//--- logic/eam_index_calc.sv
// sized, scaled and optionally suppressed index operand
`timescale 1ns/1ps
`default_nettype none
module eam_index_calc
    import eam_pkg::*;
(
    // extension word and register value in, index out
    eam_idx_if.calc ix
);
    logic [31:0] raw;

    always_comb begin
        raw = ix.ext[EXT_WL] ? ix.rf : sext16(ix.rf[15:0]);
        if (ix.ext[EXT_FULL] && ix.ext[EXT_IS]) begin
            ix.index_val = 32'h0;
        end else begin
            ix.index_val = raw << ix.ext[EXT_SCALE_HI:EXT_SCALE_LO];
        end
    end
endmodule
`default_nettype wire

//--- tb/eam_rf_model.sv
// register file model answering the decoder's read port
`timescale 1ns/1ps
`default_nettype none
module eam_rf_model (
    // read port
    input  wire logic [3:0]  rf_sel,
    output logic      [31:0] rf_data
);
    // negative low word on data registers so word and long index differ
    assign rf_data = rf_sel[3] ? {29'h0, rf_sel[2:0]} + 32'h00000100
                               : {29'h0, rf_sel[2:0]} + 32'h0002fff0;
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the special ea mode decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import eam_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        op_valid, op_write, op_first, op_ready, ext_valid, er;
    logic        ext_ready, done, illegal, ea_valid, prog_space, imm_valid;
    logic        s_ill, s_eav, s_ps, s_imv;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, op_pc, rf_data, ea_addr, imm_data, rd;
    logic [31:0] s_ea, s_imm;
    logic [15:0] op_word, ext_word;
    logic [1:0]  op_size;
    logic [3:0]  rf_sel;
    logic [2:0]  ext_used, s_used;
    int          err_total, n_compared;
    localparam logic [31:0] PC = 32'h00040000;

    eam_decode #(.MAX_EXT(6)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .op_valid(op_valid),
        .op_word(op_word), .op_size(op_size), .op_write(op_write),
        .op_first(op_first), .op_pc(op_pc), .op_ready(op_ready),
        .ext_valid(ext_valid), .ext_word(ext_word), .ext_ready(ext_ready),
        .rf_sel(rf_sel), .rf_data(rf_data), .done(done), .illegal(illegal),
        .ea_valid(ea_valid), .prog_space(prog_space), .ea_addr(ea_addr),
        .imm_valid(imm_valid), .imm_data(imm_data), .ext_used(ext_used));
    eam_rf_model rfm (.rf_sel(rf_sel), .rf_data(rf_data));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (!pready && k < 20);
        rd = prdata;
        er = pslverr;
        if (k >= 20) err_total++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // offers one operation and its words, then captures the result
    task automatic run(input logic [15:0] ow, input logic [1:0] sz,
                       input logic wr, input logic fst, input int n,
                       input logic [15:0] w0, input logic [15:0] w1,
                       input logic [15:0] w2);
        logic [15:0] w[3];
        int          i, k;
        w = '{w0, w1, w2};
        op_valid <= 1'b1;
        op_word <= ow;
        op_size <= sz;
        op_write <= wr;
        op_first <= fst;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (!op_ready && k < 20);
        op_valid <= 1'b0;
        for (i = 0; i < n && !done; i++) begin
            ext_valid <= 1'b1;
            ext_word <= w[i];
            do begin
                @(posedge pclk);
                k++;
            end while (!ext_ready && !done && k < 40);
        end
        ext_valid <= 1'b0;
        while (!done && k < 60) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 60) err_total++;
        {s_ill, s_eav, s_ps, s_imv} = {illegal, ea_valid, prog_space,
                                       imm_valid};
        {s_ea, s_imm, s_used} = {ea_addr, imm_data, ext_used};
    endtask

    task automatic chk_ea(input logic [31:0] a, input logic [2:0] u,
                          input logic ps);
        chk(s_ill, 1'b0);
        chk(s_eav, 1'b1);
        chk(s_ea, a);
        chk(s_used, u);
        chk(s_ps, ps);
    endtask

    function automatic logic [15:0] fx(input logic [3:0] r, input logic wl,
        input logic [1:0] sc, input logic [1:0] sb, input logic [1:0] bd,
        input logic [2:0] ii);
        fx = {r, wl, sc, 1'b1, sb, bd, 1'b0, ii};
    endfunction

    task automatic t_regs();
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h1);
        chk(er, 1'b0);
        apb(1'b0, 8'h10, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h0);
        repeat (2) @(posedge pclk);
        chk(op_ready, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h1);
        repeat (2) @(posedge pclk);
    endtask

    task automatic t_abs();
        run(16'h0038, SZ_WORD, 1'b0, 1'b1, 1, 16'h8000, 16'h0, 16'h0);
        chk_ea(32'hffff8000, 3'h1, 1'b0);
        run(16'h0039, SZ_LONG, 1'b0, 1'b1, 2, 16'h1234, 16'h5678, 16'h0);
        chk_ea(32'h12345678, 3'h2, 1'b0);
        apb(1'b0, ADDR_LAST, 32'h0);
        chk(rd, 32'h12345678);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(rd, 32'h8);
        apb(1'b0, ADDR_CNT, 32'h0);
        chk(rd, 32'h2);
    endtask

    task automatic t_imm();
        logic [1:0]  sz[3] = '{SZ_BYTE, SZ_WORD, SZ_LONG};
        logic [15:0] wa[3] = '{16'ha55a, 16'h7abc, 16'hdead};
        logic [31:0] ex[3] = '{32'h5a, 32'h7abc, 32'hdeadbeef};
        for (int i = 0; i < 3; i++) begin
            run(16'h003c, sz[i], 1'b0, 1'b1, i / 2 + 1, wa[i], 16'hbeef,
                16'h0);
            chk({s_ill, s_imv}, 2'b01);
            chk(s_imm, ex[i]);
        end
    endtask

    task automatic t_pcidx();
        logic [31:0] ix;
        for (logic [3:0] c = 0; c < 8; c++) begin
            run(16'h003b, SZ_LONG, 1'b0, 1'b1, 2,
                fx(4'h2, c[0], c[2:1], 2'b00, BD_WORD, 3'h0), 16'h8000, 16'h0);
            ix = c[0] ? 32'h0002fff2 : 32'hfffffff2;
            chk_ea(PC + (ix << c[2:1]) + 32'hffff8000, 3'h2, 1'b1);
        end
        run(16'h003b, SZ_LONG, 1'b0, 1'b1, 3,
            fx(4'hd, 1'b1, 2'h0, 2'b00, BD_LONG, 3'h0), 16'h1234, 16'h5678);
        chk_ea(PC + 32'h105 + 32'h12345678, 3'h3, 1'b1);
        run(16'h003b, SZ_LONG, 1'b0, 1'b1, 1,
            fx(4'h3, 1'b1, 2'h0, 2'b10, BD_NULL, 3'h0), 16'h0, 16'h0);
        chk_ea(32'h0002fff3, 3'h1, 1'b1);
        run(16'h003b, SZ_LONG, 1'b0, 1'b1, 2,
            fx(4'h3, 1'b1, 2'h0, 2'b01, BD_WORD, 3'h0), 16'h0010, 16'h0);
        chk_ea(PC + 32'h10, 3'h2, 1'b1);
        run(16'h003b, SZ_LONG, 1'b0, 1'b1, 1,
            fx(4'h3, 1'b1, 2'h0, 2'b11, BD_NULL, 3'h0), 16'h0, 16'h0);
        chk_ea(32'h0, 3'h1, 1'b1);
        run(16'h003a, SZ_WORD, 1'b0, 1'b1, 1, 16'hfffe, 16'h0, 16'h0);
        chk_ea(PC - 32'h2, 3'h1, 1'b1);
        run(16'h003b, SZ_LONG, 1'b0, 1'b1, 1, 16'h1afe, 16'h0, 16'h0);
        chk_ea(PC + 32'h0005ffe2 - 32'h2, 3'h1, 1'b1);
    endtask

    task automatic t_bad();
        run(16'h003b, SZ_LONG, 1'b1, 1'b1, 0,
            fx(4'h3, 1'b1, 2'h0, 2'b10, BD_NULL, 3'h0), 16'h0, 16'h0);
        chk({s_ill, s_eav}, 2'b10);
        run(16'h003b, SZ_LONG, 1'b0, 1'b1, 1,
            fx(4'h3, 1'b1, 2'h0, 2'b00, BD_NULL, 3'h1), 16'h0, 16'h0);
        chk({s_ill, s_eav}, 2'b10);
        run(16'h003b, SZ_LONG, 1'b0, 1'b1, 1,
            fx(4'h3, 1'b1, 2'h0, 2'b00, BD_RSVD, 3'h0), 16'h0, 16'h0);
        chk({s_ill, s_eav}, 2'b10);
        // refused at the operation word, so no extension word is offered
        for (int i = 0; i < 4; i++) begin
            run(i == 0 ? 16'h0028 : (i == 1 ? 16'h003d : 16'h003c),
                i == 2 ? 2'h3 : SZ_WORD, i == 3, 1'b1, 0, 16'h0, 16'h0,
                16'h0);
            chk({s_ill, s_eav, s_imv}, 3'b100);
        end
        for (int i = 0; i < 3; i++) begin
            run(i < 2 ? 16'h003b : 16'h0038, SZ_LONG, 1'b0, i == 0,
                i < 2 ? 3 : 1,
                fx(4'h3, 1'b1, 2'h0, 2'b00, BD_LONG, 3'h0), 16'h1, 16'h2);
            chk(s_ill, i == 2);
        end
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_total++;
        test_done();
    end

    initial begin
        {psel, penable, pwrite, op_valid, op_write, op_first} = 6'h00;
        {paddr, pwdata, op_word, op_size, ext_word} = '0;
        {ext_valid, presetn, err_total, n_compared} = '0;
        op_pc = PC;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        $display("regs test ended");
        t_abs();
        $display("absolute test ended");
        t_imm();
        $display("immediate test ended");
        t_pcidx();
        $display("pc index test ended");
        t_bad();
        $display("refusal test ended");
        test_done();
    end
endmodule
`default_nettype wire
